// ===== erw_pkg.sv
// Purpose: Shared types and constants for the embedded RAM read-during-write model
// Assumes: One clock for both ports, fabric logic on the same clock drives all inputs
// Notes: Mode enums are build-time choices, never changed while running
package erw_pkg;

  typedef enum logic {
    ERW_TEN_KBIT,
    ERW_LOGIC_ARRAY
  } erw_mem_kind_t;

  typedef enum logic {
    ERW_SP_NEW_DATA,
    ERW_SP_DONT_CARE
  } erw_sp_mode_t;

  typedef enum logic [1:0] {
    ERW_MP_NEW_DATA,
    ERW_MP_OLD_DATA,
    ERW_MP_DONT_CARE,
    ERW_MP_CONSTRAINED
  } erw_mp_mode_t;

  // Where a read answer comes from
  typedef enum logic [1:0] {
    ERW_SRC_MEM,
    ERW_SRC_FWD,
    ERW_SRC_UND
  } erw_src_t;

  localparam int ERW_WIDTH_DEF = 20;
  localparam int ERW_DEPTH_DEF = 512;
  localparam int ERW_PORTS = 2;
  localparam logic ERW_OUT_RST_BIT = 1'h0;
  // Undefined answers are shown as all ones, flagged on the undef output
  localparam logic ERW_UNDEF_BIT = 1'h1;

endpackage

// ===== erw_mem.sv
// Purpose: Two-port storage array with registered read data
// Assumes: Same clock on both ports; a read returns the word held before a same-edge write
// Notes: Array starts from INIT_IMAGE, which is all zero unless a preload is given
`timescale 1ns/10ps
module erw_mem
  import erw_pkg::*;
#(
  parameter int WIDTH = 20,
  parameter int DEPTH = 512,
  parameter int AW = 9,
  parameter logic [DEPTH*WIDTH-1:0] INIT_IMAGE = '0
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [1:0] re_i,
  input wire logic [1:0] we_i,
  input wire logic [1:0][AW-1:0] addr_i,
  input wire logic [1:0][WIDTH-1:0] wdata_i,
  output logic [1:0][WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = INIT_IMAGE[i*WIDTH +: WIDTH];
    end
  end

  // Port B write lands after port A; colliding writes are the user's to avoid
  always_ff @(posedge mclk_i) begin
    for (int p = 0; p < ERW_PORTS; p++) begin
      if (we_i[p]) begin
        mem[addr_i[p]] <= wdata_i[p];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= {2*WIDTH{ERW_OUT_RST_BIT}};
    end else begin
      for (int p = 0; p < ERW_PORTS; p++) begin
        if (re_i[p]) begin
          rdata_o[p] <= mem[addr_i[p]];
        end
      end
    end
  end

endmodule

// ===== erw_ram.sv
// Purpose: Dual-port embedded RAM with selectable read-during-write output behaviour
// Assumes: Ports A and B share mclk_i; inputs come from fabric logic on that clock
// Notes: Read data appear one edge after the taking edge (bypassed) or two (registered)
// Notes on behaviour
// - Ten-kbit same-port new data forwards written word
// - Same-port don't-care collision gives undefined output
// - Mixed-port collision: one reads, other writes same address
// - Logic-array mixed new data needs registered output
// - Mixed-port old data returns previous contents
// - Constrained don't care: logic-array only, undefined read
// - Collisions need one shared clock; output unknown
// - Output powers up zero; bypassed logic-array shows contents
// - Cells start zero unless preload image given
// - Preloaded array still powers up with cleared output
`timescale 1ns/10ps
module erw_ram
  import erw_pkg::*;
#(
  parameter int WIDTH = ERW_WIDTH_DEF,
  parameter int DEPTH = ERW_DEPTH_DEF,
  parameter int AW = $clog2(DEPTH),
  parameter erw_mem_kind_t MEM_KIND = ERW_TEN_KBIT,
  parameter bit OUT_REG = 1'b1,
  parameter erw_sp_mode_t SP_MODE = ERW_SP_DONT_CARE,
  parameter erw_mp_mode_t MP_MODE = ERW_MP_OLD_DATA,
  parameter logic [DEPTH*WIDTH-1:0] INIT_IMAGE = '0
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [AW-1:0] a_addr_i,
  input wire logic [WIDTH-1:0] a_wdata_i,
  input wire logic a_we_i,
  input wire logic a_re_i,
  output logic [WIDTH-1:0] a_rdata_o,
  output logic a_undef_o,
  input wire logic [AW-1:0] b_addr_i,
  input wire logic [WIDTH-1:0] b_wdata_i,
  input wire logic b_we_i,
  input wire logic b_re_i,
  output logic [WIDTH-1:0] b_rdata_o,
  output logic b_undef_o
);

  // Modes are parameters only, so no run-time path can change them
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) < DEPTH) begin : g_bad_size
    $error("erw_ram: width, depth or address width unusable");
  end
  if (SP_MODE == ERW_SP_NEW_DATA && MEM_KIND != ERW_TEN_KBIT) begin : g_bad_sp
    $error("erw_ram: same-port new data needs the ten-kbit block");
  end
  if (MP_MODE == ERW_MP_NEW_DATA && (MEM_KIND != ERW_LOGIC_ARRAY || !OUT_REG)) begin : g_bad_mpn
    $error("erw_ram: mixed-port new data needs registered logic-array memory");
  end
  if (MP_MODE == ERW_MP_OLD_DATA && MEM_KIND == ERW_LOGIC_ARRAY && !OUT_REG) begin : g_bad_mpo
    $error("erw_ram: logic-array old data needs a registered output");
  end
  if (MP_MODE == ERW_MP_CONSTRAINED && MEM_KIND != ERW_LOGIC_ARRAY) begin : g_bad_mpc
    $error("erw_ram: constrained don't care is logic-array only");
  end

  // Bypassed logic-array output follows the array, so it reads every cycle
  localparam bit LA_BYP = (MEM_KIND == ERW_LOGIC_ARRAY) && !OUT_REG;

  typedef struct packed {
    logic [1:0] v1;
    erw_src_t [1:0] k1;
    logic [1:0][WIDTH-1:0] f1;
    logic [1:0] v2;
    logic [1:0][WIDTH-1:0] d2;
    logic [1:0] u2;
    logic [1:0][WIDTH-1:0] dout;
    logic [1:0] uout;
  } erw_state_t;

  erw_state_t s_q;
  erw_state_t s_d;

  logic [1:0][AW-1:0] addr;
  logic [1:0][WIDTH-1:0] wdata;
  logic [1:0] we;
  logic [1:0] re;
  logic [1:0] rd_en;
  logic [1:0][WIDTH-1:0] mem_q;

  assign addr = {b_addr_i, a_addr_i};
  assign wdata = {b_wdata_i, a_wdata_i};
  assign we = {b_we_i, a_we_i};
  assign re = {b_re_i, a_re_i};
  assign rd_en = re | {2{LA_BYP}};

  erw_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH),
    .AW(AW),
    .INIT_IMAGE(INIT_IMAGE)
  ) u_mem (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .re_i(rd_en),
    .we_i(we),
    .addr_i(addr),
    .wdata_i(wdata),
    .rdata_o(mem_q)
  );

  always_comb begin
    logic sp;
    logic mp;
    logic [WIDTH-1:0] raw;
    logic und;
    sp = 1'b0;
    mp = 1'b0;
    raw = '0;
    und = 1'b0;
    s_d = s_q;
    for (int p = 0; p < ERW_PORTS; p++) begin
      // Stage 1: classify the read against writes on the same edge
      sp = re[p] && we[p];
      // Same clock on both ports makes the address compare meaningful
      mp = re[p] && we[1-p] && (addr[p] == addr[1-p]);
      s_d.v1[p] = rd_en[p];
      s_d.k1[p] = ERW_SRC_MEM;
      s_d.f1[p] = wdata[p];
      if (sp) begin
        if (SP_MODE == ERW_SP_NEW_DATA) begin
          s_d.k1[p] = ERW_SRC_FWD;
        end else begin
          s_d.k1[p] = ERW_SRC_UND;
        end
      end else if (mp) begin
        unique case (MP_MODE)
          ERW_MP_NEW_DATA: begin
            s_d.k1[p] = ERW_SRC_FWD;
            s_d.f1[p] = wdata[1-p];
          end
          ERW_MP_OLD_DATA: begin
            s_d.k1[p] = ERW_SRC_MEM;
          end
          ERW_MP_DONT_CARE, ERW_MP_CONSTRAINED: begin
            s_d.k1[p] = ERW_SRC_UND;
          end
        endcase
      end
      // Stage 2: resolve the answer from the array or the forwarded word
      unique case (s_q.k1[p])
        ERW_SRC_FWD: begin
          raw = s_q.f1[p];
          und = 1'b0;
        end
        ERW_SRC_UND: begin
          raw = {WIDTH{ERW_UNDEF_BIT}};
          und = 1'b1;
        end
        default: begin
          raw = mem_q[p];
          und = 1'b0;
        end
      endcase
      // Outputs hold while read enable is low, the power-saving case; the bypassed logic-array path reads every cycle and does not hold
      if (OUT_REG) begin
        s_d.v2[p] = s_q.v1[p];
        if (s_q.v1[p]) begin
          s_d.d2[p] = raw;
          s_d.u2[p] = und;
        end
        if (s_q.v2[p]) begin
          s_d.dout[p] = s_q.d2[p];
          s_d.uout[p] = s_q.u2[p];
        end
      end else begin
        s_d.v2[p] = 1'b0;
        if (s_q.v1[p]) begin
          s_d.dout[p] = raw;
          s_d.uout[p] = und;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Cleared even when a preload image sits in the array
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign a_rdata_o = s_q.dout[0];
  assign b_rdata_o = s_q.dout[1];
  assign a_undef_o = s_q.uout[0];
  assign b_undef_o = s_q.uout[1];

  // Checks
  logic seen_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_sp_new_byp: assert property (
    (SP_MODE == ERW_SP_NEW_DATA && !OUT_REG && a_re_i && a_we_i)
    |-> ##2 (a_rdata_o == $past(a_wdata_i, 2) && !a_undef_o))
    else $error("same-port new data not forwarded");

  a_sp_new_reg: assert property (
    (SP_MODE == ERW_SP_NEW_DATA && OUT_REG && b_re_i && b_we_i)
    |-> ##3 (b_rdata_o == $past(b_wdata_i, 3)))
    else $error("same-port new data late or wrong");

  a_sp_dont_care: assert property (
    (SP_MODE == ERW_SP_DONT_CARE && a_re_i && a_we_i)
    |-> ##[2:3] a_undef_o)
    else $error("same-port collision not flagged undefined");

  a_mp_new_data: assert property (
    (MP_MODE == ERW_MP_NEW_DATA && b_re_i && !b_we_i && a_we_i && a_addr_i == b_addr_i)
    |-> ##3 (b_rdata_o == $past(a_wdata_i, 3)))
    else $error("mixed-port new data missing");

  // Old contents are what the array read register caught on the taking edge;
  // the write to the same word lands in the array behind it
  // Registered path only, which is the one both flavours can build
  a_mp_old_data: assert property (
    (MP_MODE == ERW_MP_OLD_DATA && OUT_REG && b_re_i && !b_we_i && a_we_i && a_addr_i == b_addr_i)
    |-> ##3 (b_rdata_o == $past(mem_q[1], 2)))
    else $error("mixed-port old data replaced by new");

  a_mp_old_flag: assert property (
    (MP_MODE == ERW_MP_OLD_DATA && OUT_REG && b_re_i && !b_we_i && a_we_i && a_addr_i == b_addr_i)
    |-> ##3 !b_undef_o)
    else $error("mixed-port old data flagged undefined");

  a_mp_undef: assert property (
    ((MP_MODE == ERW_MP_DONT_CARE || MP_MODE == ERW_MP_CONSTRAINED)
     && a_re_i && !a_we_i && b_we_i && a_addr_i == b_addr_i)
    |-> ##[2:3] a_undef_o)
    else $error("mixed-port collision not undefined");

  a_mp_no_false: assert property (
    // Registered answers land three sampled edges after the taking edge
    (OUT_REG && b_re_i && !b_we_i && !(a_we_i && a_addr_i == b_addr_i))
    |-> ##3 !b_undef_o)
    else $error("undefined flag without a collision");

  a_reset_clear: assert property (
    !seen_q |-> (a_rdata_o == '0 && b_rdata_o == '0 && !a_undef_o && !b_undef_o))
    else $error("output not cleared after reset");

  a_idle_hold: assert property (
    (!LA_BYP && !a_re_i && $past(!a_re_i) && $past(!a_re_i, 2) && seen_q)
    |-> ##1 $stable(a_rdata_o))
    else $error("output moved with read enable low");

  c_sp_collide: cover property (a_re_i && a_we_i);
  c_mp_collide: cover property (b_re_i && a_we_i && a_addr_i == b_addr_i);
  c_undef_seen: cover property (a_undef_o || b_undef_o);
  c_plain_read: cover property (a_re_i && !a_we_i ##2 a_rdata_o != '0);
  c_mp_forward: cover property (b_re_i && !b_we_i && a_we_i && a_addr_i == b_addr_i ##3 !b_undef_o);

  // The checks below, other than the all-ones and port B hold checks, assume the registered path: an answer is sampled
  // three edges after the edge that takes the request
  a_sp_new_flag: assert property (
    (SP_MODE == ERW_SP_NEW_DATA && OUT_REG && a_re_i && a_we_i)
    |-> ##3 (a_rdata_o == $past(a_wdata_i, 3) && !a_undef_o))
    else $error("same-port new data flagged or wrong");

  // Undefined answers must look undefined, not like a stale word
  a_sp_undef_data: assert property (
    (SP_MODE == ERW_SP_DONT_CARE && OUT_REG && a_re_i && a_we_i)
    |-> ##3 (a_rdata_o == {WIDTH{ERW_UNDEF_BIT}}))
    else $error("same-port collision data not all ones");

  // All-ones data and the flag travel together
  a_undef_ones: assert property (
    b_undef_o |-> (b_rdata_o == {WIDTH{ERW_UNDEF_BIT}}))
    else $error("undefined flag without all-ones data");

  // Forwarded word must never be marked undefined
  a_mp_new_flag: assert property (
    (MP_MODE == ERW_MP_NEW_DATA && b_re_i && !b_we_i && a_we_i && a_addr_i == b_addr_i)
    |-> ##3 !b_undef_o)
    else $error("mixed-port new data flagged undefined");

  // A plain read must never raise the flag, or users could not trust it
  a_no_false_a: assert property (
    (OUT_REG && a_re_i && !a_we_i && !(b_we_i && a_addr_i == b_addr_i))
    |-> ##3 !a_undef_o)
    else $error("port A undefined without a collision");

  // Read enable low is the power-saving case; port B must hold as well
  a_idle_hold_b: assert property (
    (!LA_BYP && !b_re_i && $past(!b_re_i) && $past(!b_re_i, 2) && seen_q)
    |-> ##1 $stable(b_rdata_o))
    else $error("port B output moved with read enable low");

endmodule

// ===== erw_fabric.sv
// Purpose: Fabric-side partner driving both RAM ports
// Assumes: Requests launched by NBA on a rising edge, taken on the next edge
// Notes: Idle cycles drop enables and flip data so stale words never look valid
`timescale 1ns/10ps
module erw_fabric #(
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic mclk_i,
  output logic [AW-1:0] a_addr_o,
  output logic [WIDTH-1:0] a_wdata_o,
  output logic a_we_o,
  output logic a_re_o,
  output logic [AW-1:0] b_addr_o,
  output logic [WIDTH-1:0] b_wdata_o,
  output logic b_we_o,
  output logic b_re_o
);
  initial begin
    {a_addr_o, a_wdata_o, a_we_o, a_re_o} = '0;
    {b_addr_o, b_wdata_o, b_we_o, b_re_o} = '0;
  end
  // Both ports launch from the one clock, so collisions stay defined
  task automatic drive(input logic [1:0] ac, input logic [AW-1:0] aa, input logic [WIDTH-1:0] ad,
                       input logic [1:0] bc, input logic [AW-1:0] ba, input logic [WIDTH-1:0] bd);
    @(posedge mclk_i);
    {a_we_o, a_re_o} <= ac;
    a_addr_o <= aa;
    a_wdata_o <= ad;
    {b_we_o, b_re_o} <= bc;
    b_addr_o <= ba;
    b_wdata_o <= bd;
  endtask
  // Read enable only when a read is wanted; don't-care collisions are issued through drive, not here
  task automatic idle();
    @(posedge mclk_i);
    {a_we_o, a_re_o, b_we_o, b_re_o} <= 4'h0;
    a_wdata_o <= ~a_wdata_o;
    b_wdata_o <= ~b_wdata_o;
  endtask
endmodule

// ===== erw_ram_tb.sv
// Purpose: Self-checking bench for two RAM flavours fed the same traffic
// Assumes: Registered outputs, answers two edges after the taking edge
// Notes: Narrow, shallow arrays keep the run short
`timescale 1ns/10ps
module erw_ram_tb;
  import erw_pkg::*;
  localparam int W = 8;
  localparam int D = 16;
  localparam int A = 4;
  logic mclk_i;
  logic arst_n_i;
  logic [A-1:0] aa, ba;
  logic [W-1:0] ad, bd, ar1, br1, ar2, br2;
  logic awe, are, bwe, bre, au1, bu1, au2, bu2;
  int error_cnt = 0;
  int check_count = 0;
  erw_fabric #(.WIDTH(W), .AW(A)) u_erw_fabric (.mclk_i(mclk_i), .a_addr_o(aa), .a_wdata_o(ad),
    .a_we_o(awe), .a_re_o(are), .b_addr_o(ba), .b_wdata_o(bd), .b_we_o(bwe), .b_re_o(bre));
  // Modes fixed per instance at build time; word 1 preloaded in the first
  erw_ram #(.WIDTH(W), .DEPTH(D), .AW(A), .MEM_KIND(ERW_TEN_KBIT), .OUT_REG(1'b1), .SP_MODE(ERW_SP_NEW_DATA),
    .MP_MODE(ERW_MP_OLD_DATA), .INIT_IMAGE(128'h5A00)) u_erw_ram (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .a_addr_i(aa), .a_wdata_i(ad), .a_we_i(awe), .a_re_i(are), .a_rdata_o(ar1), .a_undef_o(au1),
    .b_addr_i(ba), .b_wdata_i(bd), .b_we_i(bwe), .b_re_i(bre), .b_rdata_o(br1), .b_undef_o(bu1));
  erw_ram #(.WIDTH(W), .DEPTH(D), .AW(A), .MEM_KIND(ERW_LOGIC_ARRAY), .OUT_REG(1'b1), .SP_MODE(ERW_SP_DONT_CARE),
    .MP_MODE(ERW_MP_NEW_DATA)) u_erw_ram_la (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .a_addr_i(aa), .a_wdata_i(ad), .a_we_i(awe), .a_re_i(are), .a_rdata_o(ar2), .a_undef_o(au2),
    .b_addr_i(ba), .b_wdata_i(bd), .b_we_i(bwe), .b_re_i(bre), .b_rdata_o(br2), .b_undef_o(bu2));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic t_reset();
    #1;
    check("a_rdata in reset", ar1, 8'h00);
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    settle(1);
    check("preloaded a_rdata", ar1, 8'h00);
    check("b_rdata", br1, 8'h00);
    check("la a_rdata", ar2, 8'h00);
    check("la b_undef", {7'h00, bu2}, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_init();
    u_erw_fabric.drive(2'h1, 4'h1, 8'h00, 2'h1, 4'h1, 8'h00);
    u_erw_fabric.idle();
    settle(3);
    check("image a_rdata", ar1, 8'h5A);
    check("image b_rdata", br1, 8'h5A);
    check("blank a_rdata", ar2, 8'h00);
    $display("t_init done");
  endtask
  task automatic t_same();
    u_erw_fabric.drive(2'h3, 4'h2, 8'h3C, 2'h0, 4'h0, 8'h00);
    u_erw_fabric.idle();
    settle(3);
    check("new a_rdata", ar1, 8'h3C);
    check("new a_undef", {7'h00, au1}, 8'h00);
    check("dc a_rdata", ar2, 8'hFF);
    check("dc a_undef", {7'h00, au2}, 8'h01);
    u_erw_fabric.drive(2'h1, 4'h2, 8'h00, 2'h0, 4'h0, 8'h00);
    u_erw_fabric.idle();
    settle(3);
    check("dc stored", ar2, 8'h3C);
    $display("t_same done");
  endtask
  task automatic t_mixed();
    u_erw_fabric.drive(2'h2, 4'h3, 8'hC3, 2'h1, 4'h3, 8'h00);
    u_erw_fabric.drive(2'h0, 4'h0, 8'h00, 2'h1, 4'h3, 8'h00);
    u_erw_fabric.idle();
    settle(1);
    check("old b_rdata", br1, 8'h00);
    check("old b_undef", {7'h00, bu1}, 8'h00);
    check("new b_rdata", br2, 8'hC3);
    check("new b_undef", {7'h00, bu2}, 8'h00);
    settle(1);
    check("after b_rdata", br1, 8'hC3);
    check("la after", br2, 8'hC3);
    $display("t_mixed done");
  endtask
  task automatic t_hold();
    u_erw_fabric.drive(2'h2, 4'h4, 8'h99, 2'h2, 4'h5, 8'h66);
    u_erw_fabric.idle();
    settle(3);
    check("held a_rdata", ar1, 8'h3C);
    check("held b_rdata", br1, 8'hC3);
    $display("t_hold done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    arst_n_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    t_reset();
    t_init();
    t_same();
    t_mixed();
    t_hold();
    wrap_up();
  end
  // A hang counts as a mismatch
  initial begin
    repeat (2000) @(posedge mclk_i);
    error_cnt++;
    wrap_up();
  end
endmodule
